// ==== hdl/teb_event_slave.sv ====
// event buffer I2C slave of the touch controller
//
// Behaviour
// RL1: reset leaves device in configuration loading mode
// RL2: valid profile plus mode command enters sensing
// RL3: one qualified event makes one whole packet
// RL4: bytes go out most significant bit first
// RL5: address, counter-and-type byte, two description bytes
// RL6: four-bit counter in upper nibble, wraps
// RL7: counter clears on entering sensing mode
// RL8: event type sits in lower nibble
// RL9: touch 0x0, release 0x1, proximity 0x3
// RL10: load commands 0x8 to 0xc in nibble
// RL11: sensor index then 0x00; proximity both zero
// RL12: pop only after last packet byte sent
// RL13: partial read resends packet from start
// RL14: early stop resets machine, keeps event
// RL15: empty buffer in sensing NACKs read address
// RL16: buffer holds twenty-two packets in order
// RL17: full buffer drops oldest events first
// RL18: at most twelve packets per scan period
// RL19: host should drain promptly at 400 kHz
// RL20: interrupt active while any packet queued
// RL21: sensing interrupt is active-low push-pull output
// RL22: sensing answers only the profile slave address
`timescale 1ns/1ps
`include "teb_consts.svh"
module teb_event_slave
	import teb_pkg::*;
#(
	parameter int DEPTH = `TEB_FIFO_DEPTH,
	parameter int MAX_PER_PERIOD = `TEB_MAX_PER_PERIOD
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input teb_i2c_in_t i2cIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic intIn,
	output logic intOut_n,
	output logic intOe,
	input wire logic evValid,
	input teb_evt_t evData,
	input wire logic scanTick,
	input wire logic profileValid,
	input wire logic [`TEB_ADDR_W-1:0] slaveAddr,
	output logic sensingMode
);

	teb_cond_t cond;
	teb_state_t state;
	teb_pkt_t pushPkt;
	teb_pkt_t headPkt;
	logic [3:0] pktCnt;
	logic [3:0] perPeriod;
	logic [3:0] bitCnt;
	logic [7:0] shift;
	logic [1:0] byteIdx;
	logic [3:0] cmd;
	logic rw;
	logic modeReq;
	logic fifoEmpty;
	logic pushOk;
	logic pop;
	logic addrHit;
	logic lastByte;
	logic [7:0] txFirst;
	logic [7:0] txNext;

	// ------------------------------------------------------------
	// bus conditions and packet buffer
	// ------------------------------------------------------------
	teb_bus_cond u_cond (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pins(i2cIn),
		.cond(cond)
	);

	// RL16: twenty-two entry queue
	// RL17: full queue drops oldest
	teb_event_fifo #(
		.WIDTH($bits(teb_pkt_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.push(pushOk),
		.pushData(pushPkt),
		.pop(pop),
		.headData(headPkt),
		.empty(fifoEmpty)
	);

	// ------------------------------------------------------------
	// operating mode
	// ------------------------------------------------------------
	// RL1: reset into loading mode
	// RL2: sticky switch on stop after command
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sensingMode <= 1'b0;
		end else if (cond.stop & modeReq & profileValid) begin
			sensingMode <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// packet building
	// ------------------------------------------------------------
	// RL18: period budget caps pushes
	assign pushOk = sensingMode & evValid & (perPeriod < 4'(MAX_PER_PERIOD));

	// RL3: one packet per event
	// RL9: type codes by event kind
	// RL11: description byte by event kind
	always_comb begin
		pushPkt.cnt = pktCnt;
		pushPkt.typ = `TEB_TYPE_PROX;
		pushPkt.desc = `TEB_ZERO_BYTE;
		case (evData.kind)
			TEB_KIND_TOUCH: begin
				pushPkt.typ = `TEB_TYPE_TOUCH;
				pushPkt.desc = evData.sensorIndex;
			end
			TEB_KIND_RELEASE: begin
				pushPkt.typ = `TEB_TYPE_RELEASE;
				pushPkt.desc = evData.sensorIndex;
			end
			default: begin
				pushPkt.typ = `TEB_TYPE_PROX;
				pushPkt.desc = `TEB_ZERO_BYTE;
			end
		endcase
	end

	// RL6: wrapping packet counter
	// RL7: cleared until sensing starts
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pktCnt <= `TEB_CNT_RST;
		end else if (~sensingMode) begin
			pktCnt <= `TEB_CNT_RST;
		end else if (pushOk) begin
			pktCnt <= pktCnt + 4'h1;
		end
	end

	// RL18: packets counted per scan period
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			perPeriod <= 4'h0;
		end else if (scanTick) begin
			perPeriod <= 4'h0;
		end else if (pushOk) begin
			perPeriod <= perPeriod + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// interrupt pin
	// ------------------------------------------------------------
	// RL20: active while queue holds packets
	// RL21: driven low-active only in sensing
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			intOut_n <= 1'b1;
			intOe <= 1'b0;
		end else begin
			intOut_n <= fifoEmpty;
			intOe <= sensingMode;
		end
	end

	// ------------------------------------------------------------
	// transmit byte selection
	// ------------------------------------------------------------
	// RL5: counter-type, description, zero byte
	function automatic logic [7:0] teb_tx_byte(input logic [1:0] idx);
		logic [7:0] b;
		b = `TEB_IDLE_BYTE;
		if (~sensingMode) begin
			b = profileValid ? `TEB_PROFILE_OK : `TEB_PROFILE_BAD;
		end else if (fifoEmpty) begin
			b = `TEB_IDLE_BYTE;
		end else if (idx == 2'h0) begin
			// RL8: type in low nibble
			b = {headPkt.cnt, headPkt.typ};
		end else if (idx == 2'h1) begin
			b = headPkt.desc;
		end else begin
			b = `TEB_ZERO_BYTE;
		end
		return b;
	endfunction

	// process form so head, mode and fill changes re-evaluate the bytes
	always_comb begin
		txFirst = teb_tx_byte(2'h0);
		txNext = teb_tx_byte(byteIdx);
	end
	assign lastByte = ~sensingMode | (byteIdx == `TEB_LAST_BYTE);

	// ------------------------------------------------------------
	// address match
	// ------------------------------------------------------------
	// RL22: profile address in sensing
	// RL15: reads refused while empty
	always_comb begin
		if (sensingMode) begin
			addrHit = (shift[7:1] == slaveAddr) & ~(shift[0] & fifoEmpty);
		end else begin
			addrHit = (shift[7:1] == `TEB_CFG_ADDR) & ~intIn;
		end
	end

	// RL12: pop as the last byte is acknowledged or not
	assign pop = sensingMode & (state == TEB_ST_TACK) & cond.sclRise & lastByte & ~fifoEmpty;

	// ------------------------------------------------------------
	// slave state machine
	// ------------------------------------------------------------
	// RL14: stop or start restarts the machine
	// RL13: byte index restarts at each start
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= TEB_ST_IDLE;
			bitCnt <= 4'h0;
			shift <= 8'h00;
			byteIdx <= 2'h0;
			rw <= 1'b0;
			sdaOe <= 1'b0;
		end else if (cond.start) begin
			state <= TEB_ST_ADDR;
			bitCnt <= 4'h0;
			byteIdx <= 2'h0;
			sdaOe <= 1'b0;
		end else if (cond.stop) begin
			state <= TEB_ST_IDLE;
			sdaOe <= 1'b0;
		end else begin
			case (state)
				TEB_ST_ADDR: begin
					if (cond.sclRise) begin
						shift <= {shift[6:0], cond.sda};
						bitCnt <= bitCnt + 4'h1;
					end else if (cond.sclFall & (bitCnt == 4'h8)) begin
						rw <= shift[0];
						sdaOe <= addrHit;
						state <= addrHit ? TEB_ST_AACK : TEB_ST_IDLE;
					end
				end
				TEB_ST_AACK: begin
					if (cond.sclFall) begin
						// RL4: first bit is the top bit
						if (rw) begin
							shift <= txFirst;
							sdaOe <= ~txFirst[7];
							bitCnt <= 4'h1;
							state <= TEB_ST_TX;
						end else begin
							sdaOe <= 1'b0;
							bitCnt <= 4'h0;
							state <= TEB_ST_RX;
						end
					end
				end
				TEB_ST_TX: begin
					if (cond.sclFall) begin
						if (bitCnt == 4'h8) begin
							sdaOe <= 1'b0;
							state <= TEB_ST_TACK;
						end else begin
							// RL4: shift toward the top
							sdaOe <= ~shift[6];
							shift <= {shift[6:0], 1'b0};
							bitCnt <= bitCnt + 4'h1;
						end
					end
				end
				TEB_ST_TACK: begin
					if (cond.sclRise) begin
						byteIdx <= lastByte ? 2'h0 : byteIdx + 2'h1;
						if (cond.sda) begin
							state <= TEB_ST_IDLE;
						end
					end else if (cond.sclFall) begin
						shift <= txNext;
						sdaOe <= ~txNext[7];
						bitCnt <= 4'h1;
						state <= TEB_ST_TX;
					end
				end
				TEB_ST_RX: begin
					if (cond.sclRise) begin
						shift <= {shift[6:0], cond.sda};
						bitCnt <= bitCnt + 4'h1;
					end else if (cond.sclFall & (bitCnt == 4'h8)) begin
						sdaOe <= 1'b1;
						state <= TEB_ST_RACK;
					end
				end
				TEB_ST_RACK: begin
					if (cond.sclFall) begin
						sdaOe <= 1'b0;
						bitCnt <= 4'h0;
						byteIdx <= (byteIdx == 2'h3) ? byteIdx : byteIdx + 2'h1;
						state <= TEB_ST_RX;
					end
				end
				default: begin
					sdaOe <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// command capture in loading mode
	// ------------------------------------------------------------
	// RL10: command nibble of first data byte
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd <= 4'h0;
			modeReq <= 1'b0;
		end else if (cond.start) begin
			modeReq <= 1'b0;
		end else if ((state == TEB_ST_RACK) & cond.sclFall & ~sensingMode) begin
			if (byteIdx == 2'h0) begin
				cmd <= shift[3:0];
			end else if (byteIdx == 2'h1) begin
				modeReq <= (cmd == `TEB_CMD_MODE) & (shift == `TEB_MODE_ARG);
			end
		end
	end

	// open-drain data pin only ever pulls low
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_last_sent;
		(state == TEB_ST_TACK) && sensingMode && byteIdx == `TEB_LAST_BYTE && !fifoEmpty
			&& cond.sclRise;
	endsequence

	sequence s_mode_cmd;
		cond.stop && modeReq && profileValid;
	endsequence

	property p_load_stays;
		!sensingMode && !(cond.stop && modeReq && profileValid) |=> !sensingMode;
	endproperty
	a_load_stays: assert property (p_load_stays) else $error("left loading mode"); // RL1

	property p_mode_enter;
		s_mode_cmd |=> sensingMode ##1 sensingMode;
	endproperty
	a_mode_enter: assert property (p_mode_enter) else $error("no sensing entry"); // RL2

	property p_cnt_clear;
		$rose(sensingMode) |-> pktCnt == 4'h0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter not clear"); // RL7

	property p_cnt_step;
		pushOk |=> pktCnt == 4'($past(pktCnt) + 4'h1);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong"); // RL6

	property p_prox_pkt;
		pushOk && evData.kind == TEB_KIND_PROX |-> pushPkt.typ == 4'h3 && pushPkt.desc == 8'h00;
	endproperty
	a_prox_pkt: assert property (p_prox_pkt) else $error("proximity packet wrong"); // RL11

	property p_pop_last;
		pop |-> s_last_sent;
	endproperty
	a_pop_last: assert property (p_pop_last) else $error("pop before last byte"); // RL12

	property p_stop_keeps;
		cond.stop |-> !pop ##1 state == TEB_ST_IDLE;
	endproperty
	a_stop_keeps: assert property (p_stop_keeps) else $error("pop on stop"); // RL14

	property p_nack_empty;
		(state == TEB_ST_ADDR) && sensingMode && fifoEmpty && shift[0] && cond.sclFall
			&& bitCnt == 4'h8 |=> !sdaOe && state == TEB_ST_IDLE;
	endproperty
	a_nack_empty: assert property (p_nack_empty) else $error("empty read acked"); // RL15

	property p_int_level;
		sensingMode && !fifoEmpty |=> !intOut_n && intOe;
	endproperty
	a_int_level: assert property (p_int_level) else $error("interrupt not active"); // RL20

	property p_budget;
		perPeriod == 4'(MAX_PER_PERIOD) && !scanTick |=> perPeriod == 4'(MAX_PER_PERIOD);
	endproperty
	a_budget: assert property (p_budget) else $error("period budget exceeded"); // RL18

endmodule

// ==== common/teb_consts.svh ====
// constants of the touch event buffer I2C slave
`ifndef TEB_CONSTS_SVH
`define TEB_CONSTS_SVH

// ------------------------------------------------------------
// bus addresses
// ------------------------------------------------------------
`define TEB_CFG_ADDR 7'h60
`define TEB_ADDR_W 7

// ------------------------------------------------------------
// event types in sensing mode
// ------------------------------------------------------------
`define TEB_TYPE_TOUCH 4'h0
`define TEB_TYPE_RELEASE 4'h1
`define TEB_TYPE_PROX 4'h3

// ------------------------------------------------------------
// command types in configuration loading mode
// ------------------------------------------------------------
`define TEB_CMD_MODE 4'h8
`define TEB_CMD_UNLOCK 4'h9
`define TEB_CMD_ERASE 4'ha
`define TEB_CMD_WRCFG 4'hb
`define TEB_CMD_WRCRC 4'hc
`define TEB_MODE_ARG 8'h01

// ------------------------------------------------------------
// data bytes and sizes
// ------------------------------------------------------------
`define TEB_PROFILE_OK 8'h80
`define TEB_PROFILE_BAD 8'h01
`define TEB_ZERO_BYTE 8'h00
`define TEB_IDLE_BYTE 8'hff
`define TEB_FIFO_DEPTH 22
`define TEB_MAX_PER_PERIOD 12
`define TEB_LAST_BYTE 2'h2
`define TEB_CNT_RST 4'h0

`endif

// ==== common/teb_pkg.sv ====
// types of the touch event buffer I2C slave
package teb_pkg;

	// kind of qualified event from the sensing engine
	typedef enum logic [1:0] {
		TEB_KIND_TOUCH = 2'h0,
		TEB_KIND_RELEASE = 2'h1,
		TEB_KIND_PROX = 2'h2
	} teb_kind_t;

	// event as offered by the sensing engine
	typedef struct packed {
		teb_kind_t kind;
		logic [7:0] sensorIndex;
	} teb_evt_t;

	// queued packet: counter, type, first description byte
	typedef struct packed {
		logic [3:0] cnt;
		logic [3:0] typ;
		logic [7:0] desc;
	} teb_pkt_t;

	// sampled bus pins
	typedef struct packed {
		logic scl;
		logic sda;
	} teb_i2c_in_t;

	// bus conditions seen by the slave
	typedef struct packed {
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
		logic sda;
	} teb_cond_t;

	// slave state machine, one-hot
	typedef enum logic [6:0] {
		TEB_ST_IDLE = 7'h01,
		TEB_ST_ADDR = 7'h02,
		TEB_ST_AACK = 7'h04,
		TEB_ST_TX = 7'h08,
		TEB_ST_TACK = 7'h10,
		TEB_ST_RX = 7'h20,
		TEB_ST_RACK = 7'h40
	} teb_state_t;

endpackage

// ==== hdl/teb_bus_cond.sv ====
// start, stop and clock edge detection on the I2C pins
`timescale 1ns/1ps
module teb_bus_cond
	import teb_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input teb_i2c_in_t pins,
	output teb_cond_t cond
);

	teb_i2c_in_t last;

	// ------------------------------------------------------------
	// previous pin levels
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			last <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			last <= pins;
		end
	end

	// sda moving while scl high marks start or stop
	always_comb begin
		cond.sclRise = pins.scl & ~last.scl;
		cond.sclFall = ~pins.scl & last.scl;
		cond.start = pins.scl & last.scl & last.sda & ~pins.sda;
		cond.stop = pins.scl & last.scl & ~last.sda & pins.sda;
		cond.sda = pins.sda;
	end

endmodule

// ==== hdl/teb_event_fifo.sv ====
// packet memory, first in first out, oldest dropped when full
`timescale 1ns/1ps
module teb_event_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 22
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic push,
	input wire logic [WIDTH-1:0] pushData,
	input wire logic pop,
	output logic [WIDTH-1:0] headData,
	output logic empty
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULLCNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic full;
	logic advance;

	assign full = (count == FULLCNT);
	// a push into a full buffer throws the oldest entry away
	assign advance = (pop & ~empty) | (push & full);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr] <= pushData;
		end
	end

	// pointers wrap at the depth, not at a power of two
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
			end
			if (advance) begin
				rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
			end
		end
	end

	// fill level
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
		end else if (push & ~full & ~(pop & ~empty)) begin
			count <= count + 1'b1;
		end else if (~push & pop & ~empty) begin
			count <= count - 1'b1;
		end
	end

	// registered head entry and empty flag
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			headData <= '0;
			empty <= 1'b1;
		end else begin
			headData <= mem[rdPtr];
			empty <= (count == '0);
		end
	end

endmodule

// ==== tb/teb_i2c_master.sv ====
// bus master model for the event buffer slave
`timescale 1ns/1ps
module teb_i2c_master (
	input wire logic mclk,
	input wire logic sdaIn,
	output logic scl,
	output logic sdaDrv
);
	// bus idles released, clock stands high outside frames
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	// one third of a bit time
	task automatic hold();
		repeat (4) @(negedge mclk);
	endtask

	// start or repeated start
	task automatic start();
		sdaDrv = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sdaDrv = 1'b0;
		hold();
		scl = 1'b0;
		hold();
	endtask

	// msb first
	// nine bits out and in, data bits then the acknowledge bit
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sdaDrv = tx[i];
			hold();
			scl = 1'b1;
			hold();
			rx[i] = sdaIn; // read where the high phase ends
			scl = 1'b0;
			hold();
		end
	endtask

	// stop condition
	task automatic stop();
		sdaDrv = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sdaDrv = 1'b1;
		hold();
	endtask
endmodule

// ==== tb/teb_event_slave_tb.sv ====
// self-checking bench of the event buffer slave
`timescale 1ns/1ps
`include "teb_consts.svh"
module teb_event_slave_tb
	import teb_pkg::*;
;
	typedef struct packed {
		teb_kind_t kind;
		logic [7:0] idx;
		logic [3:0] typ;
		logic [7:0] desc;
	} teb_row_t;
	localparam logic [6:0] ADR = 7'h2a;
	logic mclk = 1'b0;
	logic sys_rst, scl, sdaDrv, sdaOut, sdaOe, intOut_n, intOe, hostCs;
	logic evValid, scanTick, profileValid, sensingMode, nak;
	logic [6:0] slaveAddr;
	logic [23:0] got;
	logic [15:0] exp;
	teb_evt_t evData;
	teb_i2c_in_t i2cIn;
	wire logic intIn;
	int failures, n_checks;
	teb_row_t rows [4] = '{
		'{TEB_KIND_TOUCH, 8'h05, `TEB_TYPE_TOUCH, 8'h05},
		'{TEB_KIND_RELEASE, 8'h0b, `TEB_TYPE_RELEASE, 8'h0b},
		'{TEB_KIND_PROX, 8'h07, `TEB_TYPE_PROX, 8'h00},
		'{TEB_KIND_TOUCH, 8'h00, `TEB_TYPE_TOUCH, 8'h00}
	};
	logic [3:0] cmds [4] = '{`TEB_CMD_UNLOCK, `TEB_CMD_ERASE, `TEB_CMD_WRCFG, `TEB_CMD_WRCRC};

	always #20 mclk = ~mclk;

	// wire levels: pull-up on data, interrupt pin shared with host select
	assign i2cIn = {scl, sdaOe ? (sdaDrv & sdaOut) : sdaDrv};
	assign intIn = intOe ? intOut_n : hostCs;

	teb_event_slave #(.DEPTH(`TEB_FIFO_DEPTH), .MAX_PER_PERIOD(`TEB_MAX_PER_PERIOD))
	teb_event_slave_inst (
		.mclk(mclk), .sys_rst(sys_rst), .i2cIn(i2cIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.intIn(intIn), .intOut_n(intOut_n), .intOe(intOe), .evValid(evValid),
		.evData(evData), .scanTick(scanTick), .profileValid(profileValid),
		.slaveAddr(slaveAddr), .sensingMode(sensingMode)
	);

	teb_i2c_master teb_i2c_master_inst (
		.mclk(mclk), .sdaIn(i2cIn.sda), .scl(scl), .sdaDrv(sdaDrv)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic push(input teb_kind_t k, input logic [7:0] idx);
		evData = '{kind: k, sensorIndex: idx};
		evValid = 1'b1;
		@(negedge mclk);
		evValid = 1'b0;
		@(negedge mclk);
	endtask

	task automatic tick();
		scanTick = 1'b1;
		@(negedge mclk);
		scanTick = 1'b0;
		@(negedge mclk);
	endtask

	// read n bytes, last one refused by the master; cs pulls the select low
	task automatic rd(input logic [6:0] adr, input int n, input logic cs,
		output logic na, output logic [23:0] g);
		logic [8:0] r;
		g = '0;
		hostCs = ~cs;
		@(negedge mclk);
		teb_i2c_master_inst.start();
		teb_i2c_master_inst.xfer({adr, 1'b1, 1'b1}, r);
		na = r[0];
		if (na === 1'b0) begin
			for (int i = 0; i < n; i++) begin
				teb_i2c_master_inst.xfer({8'hff, i == n - 1}, r);
				g = {g[15:0], r[8:1]};
			end
		end
		teb_i2c_master_inst.stop();
		hostCs = 1'b1;
		@(negedge mclk);
	endtask

	// two-byte write to the loading address under chip select
	task automatic wr(input logic [7:0] b1, output logic na);
		logic [8:0] r;
		hostCs = 1'b0;
		@(negedge mclk);
		teb_i2c_master_inst.start();
		teb_i2c_master_inst.xfer({`TEB_CFG_ADDR, 1'b0, 1'b1}, r);
		na = r[0];
		teb_i2c_master_inst.xfer({b1, 1'b1}, r);
		teb_i2c_master_inst.xfer({`TEB_MODE_ARG, 1'b1}, r);
		teb_i2c_master_inst.stop();
		hostCs = 1'b1;
		@(negedge mclk);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		hostCs = 1'b1;
		evValid = 1'b0;
		evData = '0;
		scanTick = 1'b0;
		profileValid = 1'b0;
		slaveAddr = ADR;
		failures = 0;
		n_checks = 0;
		repeat (16) @(negedge mclk);
		chk("mode in reset", sensingMode, 1'b0);
		chk("int drive in reset", {intOe, intOut_n, sdaOe, sdaOut}, 4'h4);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
		// loading mode answers only under chip select
		rd(`TEB_CFG_ADDR, 1, 1'b0, nak, got);
		chk("no select nak", nak, 1'b1);
		rd(`TEB_CFG_ADDR, 1, 1'b1, nak, got);
		chk("bad profile", got, `TEB_PROFILE_BAD);
		foreach (cmds[i]) begin
			wr({4'h0, cmds[i]}, nak);
			chk("cmd ack", nak, 1'b0);
			chk("cmd keeps mode", sensingMode, 1'b0);
		end
		wr({4'h0, `TEB_CMD_MODE}, nak);
		chk("invalid profile stays", sensingMode, 1'b0);
		profileValid = 1'b1;
		rd(`TEB_CFG_ADDR, 1, 1'b1, nak, got);
		chk("good profile", got, `TEB_PROFILE_OK);
		wr({4'h0, `TEB_CMD_MODE}, nak);
		chk("sensing entered", sensingMode, 1'b1);
		chk("int push-pull idle", {intOe, intOut_n}, 2'h3);
		rd(ADR, 3, 1'b0, nak, got);
		chk("empty nak", nak, 1'b1);
		// one packet per event, table driven
		tick();
		foreach (rows[i]) push(rows[i].kind, rows[i].idx);
		repeat (4) @(negedge mclk);
		chk("int active", intOut_n, 1'b0);
		rd(ADR + 7'h01, 3, 1'b0, nak, got);
		chk("foreign addr nak", nak, 1'b1);
		// host drains as soon as the interrupt shows
		foreach (rows[i]) begin
			rd(ADR, 3, 1'b0, nak, got);
			chk("row ack", nak, 1'b0);
			chk("row pkt", got, {i[3:0], rows[i].typ, rows[i].desc, 8'h00});
		end
		chk("int cleared", intOut_n, 1'b1);
		push(TEB_KIND_TOUCH, 8'h09);
		repeat (4) @(negedge mclk);
		rd(ADR, 1, 1'b0, nak, got);
		chk("part one", got, {4'h4, `TEB_TYPE_TOUCH});
		rd(ADR, 2, 1'b0, nak, got);
		chk("part two", got, {4'h4, `TEB_TYPE_TOUCH, 8'h09});
		rd(ADR, 3, 1'b0, nak, got);
		chk("whole", got, {4'h4, `TEB_TYPE_TOUCH, 8'h09, 8'h00});
		chk("popped", intOut_n, 1'b1);
		// period budget, overflow and counter wrap
		tick();
		for (int j = 0; j < 14; j++) push(TEB_KIND_RELEASE, 8'(j));
		tick();
		for (int j = 0; j < 12; j++) push(TEB_KIND_TOUCH, 8'h20 + 8'(j));
		repeat (4) @(negedge mclk);
		for (int k = 0; k < 23; k++) begin
			rd(ADR, 3, 1'b0, nak, got);
			chk("drain nak", nak, k == 22);
			exp = (k < 10) ? {4'(k + 7), `TEB_TYPE_RELEASE, 8'(k + 2)}
				: {4'(k + 7), `TEB_TYPE_TOUCH, 8'(k + 22)};
			if (k < 22) chk("drain pkt", got, {exp, 8'h00});
		end
		test_done();
	end

	// watchdog well beyond the expected run length
	initial begin
		#3_000_000;
		failures++;
		test_done();
	end
endmodule
